// file: hdl/flash_prot_pkg.sv
// constants, register map and pin carrier for the flash protection controller
// assumes a 40 MHz clock_i; every timing count below derives from that rate
package flash_prot_pkg;

  localparam int CLK_MHZ = 40;
  localparam int FLASH_ADDR_W = 20;
  localparam int DQ_W = 16;

  // apb register map, byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS  = 8'h08;
  localparam logic [7:0] RDATA_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_TEMP_UNPROT_BIT = 8;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_PROT_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;

  // reset values
  localparam logic [FLASH_ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DQ_W-1:0] DATA_RST = 16'h0000;

  // address bits that qualify the protection modes
  localparam int PROTECT_SELECT_BIT = 9;
  localparam int PROTECT_MODE_BIT = 6;
  localparam int STATUS_SELECT_BIT = 1;

  // identification-read command: three bus writes
  localparam int IDCMD_LOW_W = 11;
  localparam logic [IDCMD_LOW_W-1:0] IDCMD_ADDR_A = 11'h555;
  localparam logic [IDCMD_LOW_W-1:0] IDCMD_ADDR_B = 11'h2aa;
  localparam logic [7:0] IDCMD_DATA_0 = 8'haa;
  localparam logic [7:0] IDCMD_DATA_1 = 8'h55;
  localparam logic [7:0] IDCMD_DATA_2 = 8'h90;

  // times as printed, then cycles (least times round up)
  localparam int T_WE_PULSE_NS = 55;
  localparam int T_WE_HIGH_NS = 20;
  localparam int T_ACC_NS = 120;
  localparam int T_GLITCH_NS = 5;
  localparam int T_VLHT_US = 4;
  localparam int T_PROT_PULSE_US = 10;
  localparam int T_UNPROT_PULSE_MS = 12;
  localparam int WE_PULSE_CYC = (T_WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int GLITCH_CYC = (T_GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int VLHT_CYC = T_VLHT_US * CLK_MHZ;
  localparam int PROT_PULSE_CYC = T_PROT_PULSE_US * CLK_MHZ;
  localparam int UNPROT_PULSE_CYC = T_UNPROT_PULSE_MS * 1000 * CLK_MHZ;
  localparam int SYNC_STAGES = 3;
  localparam int CNT_W = 20;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_PROTECT, OP_UNPROTECT, OP_VERIFY, OP_IDCMD
  } flash_op_e;

  typedef struct packed {
    logic                    chip_sel_n;
    logic                    out_en_n;
    logic                    wr_strobe_n;
    logic                    flash_rst_n;
    logic                    addr_hv;   // high_voltage_level on protect_select_addr_bit
    logic                    oe_hv;     // high_voltage_level on output enable
    logic                    rst_hv;    // high_voltage_level on reset
    logic [FLASH_ADDR_W-1:0] addr;
  } flash_pins_s;

endpackage

// file: hdl/pin_sync.sv
// three-stage input synchroniser with agreement filter for asynchronous pins
// assumes pins are quasi-static around the sample point; clock enable freezes it
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 16
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
    end else if (ce_i) begin
      ff1_reg <= pin_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // a bit moves only once stages two and three agree, so a one-cycle spike is dropped
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level_o <= '0;
    end else if (ce_i) begin
      level_o <= (ff2_reg & ~(ff2_reg ^ ff3_reg)) | (level_o & (ff2_reg ^ ff3_reg));
    end
  end
endmodule

// file: hdl/flash_prot_ctrl.sv
// host controller for a parallel nor flash: bus cycles and protection modes
// assumes an apb master on the register side and the flash pins on the other;
// high-voltage levels leave as separate qualifier outputs for a board driver
//
// Summary of operation
// [RL1] Device ignores writes while output enable low or select/strobe high.
// [RL2] Controller starts writes with select and strobe low, output enable high.
// [RL3] Device rejects strobe glitches under 5ns; controller strobes stay far longer.
// [RL4] Device refuses program and erase to protected sectors.
// [RL5] Protect: high voltage on select bit and output enable, mode bit low.
// [RL6] Protection programs from strobe falling edge to rising edge.
// [RL7] Verify: high voltage on select bit, select and output enable low.
// [RL8] High-voltage reads with status-select low return identification codes.
// [RL9] After identification-read command, status-select reads report protection on bit zero.
// [RL10] Unprotect: high voltage on select bit and output enable, mode bit high.
// [RL11] After unprotect, status reads return all zeros.
// [RL12] Protecting all sectors before unprotect is advised, not enforced.
// [RL13] Device powers up in read mode; only full command sequences alter memory.
// [RL14] High voltage on reset temporarily unprotects protected sectors.
// [RL15] High-voltage levels are separate qualifier signals beside the logic pins.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module flash_prot_ctrl
  import flash_prot_pkg::*;
#(
  parameter int PROT_CYC = PROT_PULSE_CYC,
  parameter int UNPROT_CYC = UNPROT_PULSE_CYC,
  parameter int VLHT_CYCLES = VLHT_CYC
) (
  input  wire logic                             clock_i,
  input  wire logic                             sys_rst_i,
  input  wire logic                             ce_i,
  input  wire logic [7:0]                       paddr_i,
  input  wire logic                             psel_i,
  input  wire logic                             penable_i,
  input  wire logic                             pwrite_i,
  input  wire logic [31:0]                      pwdata_i,
  output logic      [31:0]                      prdata_o,
  output logic                                  pready_o,
  output logic                                  pslverr_o,
  output flash_prot_pkg::flash_pins_s           pins_o,
  input  wire logic [flash_prot_pkg::DQ_W-1:0]  dq_i,
  output logic      [flash_prot_pkg::DQ_W-1:0]  dq_o,
  output logic                                  dq_oe_o
);
  import flash_prot_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HV_RAMP, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_SAMPLE, ST_HV_FALL
  } state_e;

  state_e                  state_reg, state_next;
  flash_op_e               op_reg, op_cur, new_op;
  logic [CNT_W-1:0]        cnt_reg, cnt_next;
  logic [1:0]              step_reg, step_next;
  logic [FLASH_ADDR_W-1:0] addr_reg;
  logic [DQ_W-1:0]         wdata_reg, rdata_reg, dq_sync, dq_next;
  logic                    temp_unprot_reg, done_reg, prot_reg, refused_reg;
  logic                    rd_ready_reg, dq_oe_next;
  flash_pins_s             pins_next;
  logic                    apb_wr, apb_rd_ok, ctrl_wr, start_req, start_ok, bad_op;
  logic                    done_evt, sample_evt, hv_op;
  logic [31:0]             rd_mux;

  pin_sync #(.W(DQ_W)) u_dq_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .pin_i     (dq_i),
    .level_o   (dq_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: read data is latched from setup, so access completes at once

  assign pready_o = ce_i & rd_ready_reg;
  assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  assign apb_rd_ok = (paddr_i == CTRL_OFS) || (paddr_i == ADDR_OFS) ||
                     (paddr_i == WDATA_OFS) || (paddr_i == RDATA_OFS) ||
                     (paddr_i == STATUS_OFS);
  assign pslverr_o = pready_o & psel_i & penable_i & ~apb_rd_ok;
  assign ctrl_wr = apb_wr & (paddr_i == CTRL_OFS);
  assign start_req = ctrl_wr & pwdata_i[CTRL_START_BIT];
  assign new_op = flash_op_e'(pwdata_i[CTRL_OP_LSB +: 3]);
  assign bad_op = pwdata_i[CTRL_OP_LSB +: 3] > 3'h5;
  // a start while busy is refused and flagged; op_reg and the state stay, but the same write still updates temp_unprot_reg
  assign start_ok = start_req & (state_reg == ST_IDLE) & ~bad_op;
  assign op_cur = start_ok ? new_op : op_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      CTRL_OFS: begin
        rd_mux[CTRL_OP_LSB +: 3] = op_reg;
        rd_mux[CTRL_TEMP_UNPROT_BIT] = temp_unprot_reg;
      end
      ADDR_OFS:  rd_mux[FLASH_ADDR_W-1:0] = addr_reg;
      WDATA_OFS: rd_mux[DQ_W-1:0] = wdata_reg;
      RDATA_OFS: rd_mux[DQ_W-1:0] = rdata_reg;
      STATUS_OFS: begin
        rd_mux[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
        rd_mux[STAT_DONE_BIT] = done_reg;
        rd_mux[STAT_PROT_BIT] = prot_reg;
        rd_mux[STAT_REFUSED_BIT] = refused_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
      rd_ready_reg <= 1'b0;
    end else if (ce_i) begin
      if (psel_i) begin
        prdata_o <= rd_mux;
      end
      rd_ready_reg <= psel_i & ~(penable_i & rd_ready_reg);
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_reg <= ADDR_RST;
      wdata_reg <= DATA_RST;
      temp_unprot_reg <= 1'b0;
      op_reg <= OP_READ;
    end else if (ce_i) begin
      if (apb_wr && paddr_i == ADDR_OFS) begin
        addr_reg <= pwdata_i[FLASH_ADDR_W-1:0];
      end
      if (apb_wr && paddr_i == WDATA_OFS) begin
        wdata_reg <= pwdata_i[DQ_W-1:0];
      end
      if (ctrl_wr) begin
        temp_unprot_reg <= pwdata_i[CTRL_TEMP_UNPROT_BIT];
      end
      if (start_ok) begin
        op_reg <= new_op;
      end
    end
  end

  // sticky flags: a set in the same cycle as the write-one clear wins
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else if (ce_i) begin
      if (done_evt) begin
        done_reg <= 1'b1;
      end else if (apb_wr && paddr_i == STATUS_OFS && pwdata_i[STAT_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (start_req && !start_ok) begin
        refused_reg <= 1'b1;
      end else if (apb_wr && paddr_i == STATUS_OFS && pwdata_i[STAT_REFUSED_BIT]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign hv_op = (op_reg == OP_PROTECT) || (op_reg == OP_UNPROTECT) || (op_reg == OP_VERIFY);

  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    step_next = step_reg;
    done_evt = 1'b0;
    sample_evt = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          step_next = 2'd0;
          case (new_op)
            OP_READ: begin
              state_next = ST_READ;
              cnt_next = CNT_W'(ACC_CYC + SYNC_STAGES);
            end
            OP_WRITE, OP_IDCMD: begin
              state_next = ST_SETUP;  // [RL2]
            end
            default: begin  // [RL12] protect-all before unprotect is left to software
              state_next = ST_HV_RAMP;
              cnt_next = CNT_W'(VLHT_CYCLES - 1);
            end
          endcase
        end
      end
      ST_HV_RAMP: begin
        if (cnt_reg == '0) begin
          if (op_reg == OP_VERIFY) begin
            state_next = ST_READ;
            cnt_next = CNT_W'(ACC_CYC + SYNC_STAGES);
          end else begin
            // protection element is worked only while the strobe is low
            state_next = ST_STROBE;  // [RL6] [RL10]
            cnt_next = (op_reg == OP_PROTECT) ? CNT_W'(PROT_CYC - 1) : CNT_W'(UNPROT_CYC - 1);
          end
        end
      end
      ST_SETUP: begin
        state_next = ST_STROBE;
        cnt_next = CNT_W'(WE_PULSE_CYC - 1);  // [RL3]
      end
      ST_STROBE: begin
        if (cnt_reg == '0) begin
          state_next = hv_op ? ST_HV_FALL : ST_HOLD;
          cnt_next = hv_op ? CNT_W'(VLHT_CYCLES - 1) : CNT_W'(WE_HIGH_CYC - 1);
        end
      end
      ST_HOLD: begin
        if (cnt_reg == '0) begin
          if (op_reg == OP_IDCMD && step_reg != 2'd2) begin
            step_next = step_reg + 2'd1;  // [RL9]
            state_next = ST_SETUP;
          end else begin
            state_next = ST_IDLE;
            done_evt = 1'b1;
          end
        end
      end
      ST_READ: begin
        if (cnt_reg == '0) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        sample_evt = 1'b1;
        state_next = (op_reg == OP_VERIFY) ? ST_HV_FALL : ST_IDLE;
        cnt_next = CNT_W'(VLHT_CYCLES - 1);
        done_evt = (op_reg != OP_VERIFY);
      end
      ST_HV_FALL: begin
        if (cnt_reg == '0) begin
          state_next = ST_IDLE;
          done_evt = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // pin image for the next state, registered so no pin ever glitches
  always_comb begin
    pins_next = '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_strobe_n: 1'b1, flash_rst_n: 1'b1,
                  addr_hv: 1'b0, oe_hv: 1'b0, rst_hv: temp_unprot_reg, addr: addr_reg};  // [RL14]
    dq_next = wdata_reg;
    dq_oe_next = 1'b0;
    case (state_next)
      // qualifiers outlast the strobe, so its rising edge still ends the pulse in mode
      ST_HV_RAMP, ST_STROBE, ST_HV_FALL: begin
        pins_next.chip_sel_n = 1'b0;
        if (op_cur == OP_PROTECT || op_cur == OP_UNPROTECT) begin
          pins_next.addr_hv = 1'b1;  // [RL15]
          pins_next.oe_hv = 1'b1;  // [RL5] [RL10]
          pins_next.addr[PROTECT_MODE_BIT] = (op_cur == OP_UNPROTECT);
          pins_next.wr_strobe_n = (state_next != ST_STROBE);
        end else if (op_cur == OP_VERIFY) begin
          pins_next.addr_hv = 1'b1;
        end else begin
          pins_next.wr_strobe_n = (state_next != ST_STROBE);
          dq_oe_next = 1'b1;
        end
      end
      ST_SETUP, ST_HOLD: begin
        pins_next.chip_sel_n = 1'b0;
        dq_oe_next = 1'b1;
      end
      ST_READ, ST_SAMPLE: begin
        pins_next.chip_sel_n = 1'b0;
        pins_next.out_en_n = 1'b0;
        pins_next.addr_hv = (op_cur == OP_VERIFY);  // [RL7] [RL8]
      end
      default: pins_next.chip_sel_n = 1'b1;
    endcase
    if (op_cur == OP_IDCMD) begin
      pins_next.addr[IDCMD_LOW_W-1:0] = (step_next == 2'd1) ? IDCMD_ADDR_B : IDCMD_ADDR_A;
      dq_next = {8'h00, (step_next == 2'd0) ? IDCMD_DATA_0 :
                        (step_next == 2'd1) ? IDCMD_DATA_1 : IDCMD_DATA_2};
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      step_reg <= 2'd0;
      pins_o <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_strobe_n: 1'b1, flash_rst_n: 1'b1,
                  addr_hv: 1'b0, oe_hv: 1'b0, rst_hv: 1'b0, addr: ADDR_RST};
      dq_o <= DATA_RST;
      dq_oe_o <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      pins_o <= pins_next;
      dq_o <= dq_next;
      dq_oe_o <= dq_oe_next;
    end
  end

  // status bit zero of a status-select read reports protection
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= DATA_RST;
      prot_reg <= 1'b0;
    end else if (ce_i && sample_evt) begin
      rdata_reg <= dq_sync;
      if (addr_reg[STATUS_SELECT_BIT]) begin
        prot_reg <= dq_sync[0];  // [RL9] [RL11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  write_gate_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL1] [RL2]
    !pins_o.wr_strobe_n |-> !pins_o.chip_sel_n && pins_o.out_en_n)
    else $error("strobe low without select low and output enable high");

  strobe_width_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL3]
    ce_i && $fell(pins_o.wr_strobe_n) |-> !pins_o.wr_strobe_n[*3])
    else $error("write strobe shorter than minimum pulse");

  protect_entry_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL5]
    !pins_o.wr_strobe_n && op_reg == OP_PROTECT |->
      pins_o.addr_hv && pins_o.oe_hv && !pins_o.addr[PROTECT_MODE_BIT])
    else $error("protect strobe without protect qualifiers");

  unprot_entry_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL10]
    !pins_o.wr_strobe_n && op_reg == OP_UNPROTECT |->
      pins_o.addr_hv && pins_o.oe_hv && pins_o.addr[PROTECT_MODE_BIT])
    else $error("unprotect strobe without unprotect qualifiers");

  verify_pins_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL7]
    state_reg == ST_SAMPLE && op_reg == OP_VERIFY |->
      pins_o.addr_hv && !pins_o.oe_hv && !pins_o.out_en_n && pins_o.wr_strobe_n)
    else $error("verify read with wrong pin levels");

  hv_settle_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL6]
    ce_i && $rose(pins_o.addr_hv) |-> pins_o.wr_strobe_n[*8])
    else $error("strobe fell before high voltage settled");

  prot_capture_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL9] [RL11]
    ce_i && sample_evt && addr_reg[STATUS_SELECT_BIT] |=> prot_reg == $past(dq_sync[0]))
    else $error("protection flag not taken from data bit zero");

  temp_unprot_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL14]
    ce_i && ctrl_wr |=> ##[0:1] pins_o.rst_hv == temp_unprot_reg)
    else $error("reset high-voltage qualifier does not follow control");

  busy_refuse_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL13]
    ce_i && start_req && state_reg != ST_IDLE |=> op_reg == $past(op_reg) && refused_reg)
    else $error("start accepted while busy");

  cov_write_c: cover property (@(posedge clock_i) done_evt && op_reg == OP_WRITE);
  cov_protect_c: cover property (@(posedge clock_i) done_evt && op_reg == OP_PROTECT);
  cov_unprot_c: cover property (@(posedge clock_i) done_evt && op_reg == OP_UNPROTECT);
  cov_verify_c: cover property (@(posedge clock_i) sample_evt && op_reg == OP_VERIFY);
endmodule

// file: dv/flash_dev_model.sv
// behavioural nor flash: command writes, protection modes, id and status reads
// assumes one controller on the pins; high voltage arrives as qualifier bits
`timescale 1ns/1ps
module flash_dev_model
  import flash_prot_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h00c5,  // arbitrary value
  parameter logic [15:0] PART_ID  = 16'h2a5b   // arbitrary value
) (
  input  flash_prot_pkg::flash_pins_s          pins_i,
  input  wire logic [flash_prot_pkg::DQ_W-1:0] dq_o_i,
  input  wire logic                            dq_oe_i,
  output logic      [flash_prot_pkg::DQ_W-1:0] dq_level_o
);
  logic [15:0] prot_reg = '0;
  logic        id_mode_reg = 1'b0;
  int          n_writes = 0;
  int          n_blocked = 0;
  int          cmd_step = 0;
  realtime     t_fall = 0.0;
  logic [15:0] resp;
  logic [15:0] last_q = '0;
  logic [3:0]  sect;
  logic        rd_en;
  assign sect = pins_i.addr[19:16];
  assign rd_en = !pins_i.chip_sel_n && !pins_i.out_en_n && pins_i.wr_strobe_n;

  always @(negedge pins_i.wr_strobe_n) t_fall = $realtime;
  // strobes shorter than the glitch limit are dropped whole
  always @(posedge pins_i.wr_strobe_n) begin
    if ($realtime - t_fall >= 5.0 && !pins_i.chip_sel_n) begin
      if (pins_i.addr_hv && pins_i.oe_hv) begin
        if (!pins_i.addr[PROTECT_MODE_BIT]) prot_reg[sect] <= 1'b1;
        else prot_reg <= '0;
      end else if (pins_i.out_en_n) begin
        n_writes++;
        // writes aimed at a locked sector are counted as refused, yet still step the command sequence
        if (prot_reg[sect] && !pins_i.rst_hv) n_blocked++;
        case (cmd_step)
          0: cmd_step = (pins_i.addr[10:0] == IDCMD_ADDR_A && dq_o_i[7:0] == IDCMD_DATA_0);
          1: cmd_step = (pins_i.addr[10:0] == IDCMD_ADDR_B && dq_o_i[7:0] == IDCMD_DATA_1) ? 2 : 0;
          default: begin
            if (pins_i.addr[10:0] == IDCMD_ADDR_A && dq_o_i[7:0] == IDCMD_DATA_2) id_mode_reg <= 1;
            cmd_step = 0;
          end
        endcase
      end
    end
  end

  always_comb begin
    if (pins_i.addr_hv || id_mode_reg) begin
      if (pins_i.addr[STATUS_SELECT_BIT]) resp = {15'h0000, prot_reg[sect]};
      else resp = pins_i.addr[0] ? PART_ID : MAKER_ID;
    end else begin
      resp = pins_i.addr[15:0] ^ 16'h5a5a;
    end
  end
  // released bus shows the inverse of the last value the device drove, never a held copy
  always @(*) if (rd_en) last_q = resp;
  assign dq_level_o = rd_en ? resp : (dq_oe_i ? dq_o_i : ~last_q);
endmodule

// file: dv/flash_write_inhibit_sector_protect_bench.sv
// self-checking bench: apb master, flash model, expected values from rules
// assumes shortened protect, unprotect and settle counts on the controller
`timescale 1ns/1ps
module flash_write_inhibit_sector_protect_bench;
  import flash_prot_pkg::*;
  localparam logic [15:0] MAKER_ID = 16'h00c5;  // arbitrary value
  localparam logic [15:0] PART_ID  = 16'h2a5b;  // arbitrary value
  logic        clock_i, sys_rst_i, ce_i, psel_i, penable_i, pwrite_i;
  logic        pready_o, pslverr_o, dq_oe_o, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, seed, a;
  logic [15:0] dq_i, dq_o;
  logic [3:0]  s;
  flash_pins_s pins_o;
  flash_op_e   cur_op;
  int          errors, num_checks, cycles, n0;

  flash_prot_ctrl #(.PROT_CYC(4), .UNPROT_CYC(8), .VLHT_CYCLES(10)) i_flash_prot_ctrl (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pins_o(pins_o),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  flash_dev_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) i_flash_dev_model (
    .pins_i(pins_o), .dq_o_i(dq_o), .dq_oe_i(dq_oe_o), .dq_level_o(dq_i));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // pready is sampled at the rising edge, before that edge's updates land
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_done();
    do apb(1'b0, STATUS_OFS, 0); while (rd[STAT_BUSY_BIT] !== 1'b0);
    chk_pin(rd[STAT_DONE_BIT], 1'b1);
    apb(1'b1, STATUS_OFS, 32'h0000_0002);
  endtask
  task automatic run_op(input flash_op_e op);
    cur_op = op;
    apb(1'b1, CTRL_OFS, 32'(op) | (32'h1 << CTRL_START_BIT));
    wait_done();
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 0);
    chk32(rd, exp);
  endtask

  // every write strobe must come with select low and the mode pins right
  always @(negedge pins_o.wr_strobe_n) begin
    chk_pin(pins_o.chip_sel_n, 1'b0);
    if (cur_op == OP_PROTECT || cur_op == OP_UNPROTECT) begin
      chk_pin(pins_o.addr_hv & pins_o.oe_hv, 1'b1);
      chk_pin(pins_o.addr[PROTECT_MODE_BIT], cur_op == OP_UNPROTECT);
    end else chk_pin(pins_o.out_en_n, 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h63e1; errors = 0; num_checks = 0; cycles = 0; cur_op = OP_READ;
    sys_rst_i = 1'b1; ce_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 8'h00; pwdata_i = 32'h0;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    chk_pin(pins_o.chip_sel_n & pins_o.wr_strobe_n & ~pins_o.oe_hv, 1'b1);
    rd_chk(CTRL_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'h0);
    rd_chk(8'h20, 32'h0);
    chk_pin(err, 1'b1);
    for (int i = 0; i < 4; i++) begin
      a = xs();
      apb(1'b1, ADDR_OFS, a);
      rd_chk(ADDR_OFS, a & 32'h000f_ffff);
      apb(1'b1, WDATA_OFS, ~a);
      rd_chk(WDATA_OFS, ~a & 32'h0000_ffff);
    end
    for (int i = 0; i < 3; i++) begin
      a = xs() & 32'h000f_ffff;
      apb(1'b1, ADDR_OFS, a);
      if (i == 1) begin
        // clock enable low mid-read must freeze the cycle with the pins held
        apb(1'b1, CTRL_OFS, 32'(OP_READ) | (32'h1 << CTRL_START_BIT));
        ce_i <= 1'b0;
        repeat (20) @(posedge clock_i);
        chk_pin(pins_o.out_en_n, 1'b0);
        ce_i <= 1'b1;
        wait_done();
      end else run_op(OP_READ);
      rd_chk(RDATA_OFS, {16'h0, a[15:0] ^ 16'h5a5a});
    end
    n0 = i_flash_dev_model.n_writes;
    run_op(OP_WRITE);
    chk32(32'(i_flash_dev_model.n_writes), 32'(n0 + 1));
    a = xs();
    s = a[3:0];
    apb(1'b1, ADDR_OFS, {12'h0, s, 16'h0002});
    run_op(OP_VERIFY);
    rd_chk(RDATA_OFS, 32'h0);
    run_op(OP_PROTECT);
    run_op(OP_VERIFY);
    rd_chk(RDATA_OFS, 32'h1);
    rd_chk(STATUS_OFS, 32'h4);
    // a write to the locked sector is refused, then passes under temporary unprotect
    n0 = i_flash_dev_model.n_blocked;
    run_op(OP_WRITE);
    apb(1'b1, CTRL_OFS, 32'h0000_0111);
    wait_done();
    apb(1'b1, CTRL_OFS, 32'h0);
    chk32(32'(i_flash_dev_model.n_blocked), 32'(n0 + 1));
    apb(1'b1, ADDR_OFS, {12'h0, s ^ 4'h1, 16'h0002});
    run_op(OP_VERIFY);
    rd_chk(RDATA_OFS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_OFS, {12'h0, s, 15'h0, i[0]});
      run_op(OP_VERIFY);
      rd_chk(RDATA_OFS, {16'h0, i[0] ? PART_ID : MAKER_ID});
    end
    run_op(OP_IDCMD);
    apb(1'b1, ADDR_OFS, {12'h0, s, 16'h0002});
    run_op(OP_READ);
    rd_chk(RDATA_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h0000_0100);
    rd_chk(CTRL_OFS, 32'h0000_0100);
    chk_pin(pins_o.rst_hv, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0);
    rd_chk(CTRL_OFS, 32'h0);
    chk_pin(pins_o.rst_hv, 1'b0);
    // a second start while busy must be refused and leave the first running
    cur_op = OP_UNPROTECT;
    apb(1'b1, CTRL_OFS, 32'(OP_UNPROTECT) | (32'h1 << CTRL_START_BIT));
    apb(1'b1, CTRL_OFS, 32'(OP_READ) | (32'h1 << CTRL_START_BIT));
    apb(1'b0, STATUS_OFS, 0);
    chk_pin(rd[STAT_REFUSED_BIT], 1'b1);
    wait_done();
    apb(1'b1, STATUS_OFS, 32'h0000_0008);
    run_op(OP_READ);
    rd_chk(RDATA_OFS, 32'h0);
    run_op(OP_VERIFY);
    rd_chk(RDATA_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'h0);
    close_out();
  end
endmodule
